// ### include/gcc_pkg.sv
`default_nettype none

package gcc_pkg;

  // configuration image locations
  localparam logic [6:0]  LOC_CHECK1_LO = 7'h00;
  localparam logic [6:0]  LOC_CHECK1_HI = 7'h01;
  localparam logic [6:0]  LOC_CHECK2_LO = 7'h7e;
  localparam logic [6:0]  LOC_CHECK2_HI = 7'h7f;
  localparam logic [6:0]  LOC_SPEC      = 7'h14;
  localparam logic [6:0]  LOC_DATE      = 7'h16;
  localparam logic [6:0]  LOC_SERIAL    = 7'h18;
  localparam logic [6:0]  LOC_MFR_LEN   = 7'h20;
  localparam logic [6:0]  LOC_DEV_LEN   = 7'h30;
  localparam logic [6:0]  LOC_CHEM_LEN  = 7'h40;
  localparam logic [6:0]  LOC_MDATA_LEN = 7'h50;
  localparam logic [6:0]  LOC_VFC_OFS   = 7'h5e;
  localparam logic [6:0]  LOC_TEMP_OFS  = 7'h61;
  localparam logic [6:0]  LOC_ADC_OFS   = 7'h62;
  localparam logic [6:0]  LOC_ADC_GAIN  = 7'h68;
  localparam logic [6:0]  LOC_VFC_GAIN  = 7'h6a;

  // string field capacities in characters
  localparam logic [7:0]  MFR_CAP       = 8'h0a;
  localparam logic [7:0]  DEV_CAP       = 8'h07;
  localparam logic [7:0]  CHEM_CAP      = 8'h04;

  localparam logic [15:0] CHECK1_VALUE  = 16'h3c7f;
  localparam logic [15:0] CHECK2_VALUE  = 16'ha55a;

  // current divide by 16384 is a shift by 14
  localparam int          CUR_SHIFT     = 14;
  localparam int          VFC_SIGN_BIT  = 20;
  localparam logic [19:0] VFC_MAG_MAX   = 20'hfffff;

  // load sequence length and reset values
  localparam logic [3:0]  LOAD_STEPS    = 4'hd;
  localparam logic [3:0]  CAL_STEPS     = 4'h3;
  localparam logic [15:0] GAIN_RST      = 16'h0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;

  // apb byte offsets
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_STATUS    = 12'h004;
  localparam logic [11:0] REG_CURRENT   = 12'h008;
  localparam logic [11:0] REG_CHARGE    = 12'h00c;
  localparam logic [11:0] REG_TEMP      = 12'h010;
  localparam logic [11:0] REG_CMD       = 12'h014;
  localparam logic [11:0] REG_RESP      = 12'h018;
  localparam logic [11:0] REG_CHAR      = 12'h01c;
  localparam logic [11:0] REG_CANCEL    = 12'h020;
  localparam logic [2:0]  MEM_WINDOW    = 3'h1;

  localparam int          CTRL_LOAD     = 0;
  localparam int          CTRL_CAL      = 1;

  typedef enum logic [2:0] {
    CMD_SPEC, CMD_DATE, CMD_SERIAL, CMD_MFR_NAME, CMD_DEV_NAME, CMD_CHEM, CMD_MDATA
  } gcc_cmd_t;

  typedef struct packed {
    logic signed [15:0] adc_raw;
    logic signed [15:0] temp_raw;
    logic signed [31:0] charge_raw;
    logic signed [20:0] vfc_meas;
  } gcc_meas_t;

  typedef struct packed {
    logic signed [15:0] current_ma;
    logic signed [15:0] temperature;
    logic signed [31:0] charge;
    logic signed [20:0] vfc_cancel;
  } gcc_result_t;

endpackage : gcc_pkg

`default_nettype wire

// ### hw/gcc_cfg_mem.sv
`timescale 1ns/1ps
`default_nettype none

module gcc_cfg_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // single port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] q
);

  logic [DW-1:0] mem_array [0:(1<<AW)-1];

  // the array has no reset: the image must be written before a load
  always_ff @(posedge clk) begin
    if (we) begin
      mem_array[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= mem_array[addr];
    end
  end

endmodule : gcc_cfg_mem

`default_nettype wire

// ### hw/gcc_top.sv
`timescale 1ns/1ps
`default_nettype none

module gcc_top #(
  parameter int AW = 7
) (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // apb slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // measurement path
  input  wire gcc_pkg::gcc_meas_t   MEAS,
  output var gcc_pkg::gcc_result_t  RESULT
);
  import gcc_pkg::*;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_CAL, SEQ_CMD} gcc_seq_t;

  typedef struct packed {
    gcc_seq_t    seq;
    logic [3:0]  step;
    logic [15:0] chk1;
    logic [15:0] chk2;
    logic [23:0] vfc_ofs;
    logic [7:0]  temp_ofs;
    logic [7:0]  adc_ofs;
    logic [15:0] adc_gain;
    logic [15:0] vfc_gain;
    logic        loaded;
    logic        cal_done;
    gcc_cmd_t    cmd;
    logic [15:0] resp;
    logic [7:0]  str_len;
    logic [7:0]  str_idx;
    logic        apb_wait;
    logic        rd_mem;
    logic [31:0] prdata;
    gcc_result_t res;
  } gcc_state_t;

  gcc_state_t st_reg;
  gcc_state_t st_next;

  logic          mem_we;
  logic [AW-1:0] mem_addr;
  logic [7:0]    mem_wdata;
  logic [7:0]    mem_q;

  gcc_cfg_mem #(.AW(AW), .DW(8)) u_mem (
    .clk   (CLOCK),
    .rst   (RST),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .q     (mem_q)
  );

  // location read at each load step, little endian pairs kept together
  function automatic logic [6:0] load_loc(input logic [3:0] k);
    case (k)
      4'h0:    load_loc = LOC_CHECK1_LO;
      4'h1:    load_loc = LOC_CHECK1_HI;
      4'h2:    load_loc = LOC_CHECK2_LO;
      4'h3:    load_loc = LOC_CHECK2_HI;
      4'h4:    load_loc = LOC_VFC_OFS;
      4'h5:    load_loc = LOC_VFC_OFS + 7'h01;
      4'h6:    load_loc = LOC_VFC_OFS + 7'h02;
      4'h7:    load_loc = LOC_TEMP_OFS;
      4'h8:    load_loc = LOC_ADC_OFS;
      4'h9:    load_loc = LOC_ADC_GAIN;
      4'ha:    load_loc = LOC_ADC_GAIN + 7'h01;
      4'hb:    load_loc = LOC_VFC_GAIN;
      default: load_loc = LOC_VFC_GAIN + 7'h01;
    endcase
  endfunction : load_loc

  // first location of the answer for a command (word or length byte)
  function automatic logic [6:0] cmd_loc(input gcc_cmd_t c);
    case (c)
      CMD_SPEC:     cmd_loc = LOC_SPEC;
      CMD_DATE:     cmd_loc = LOC_DATE;
      CMD_SERIAL:   cmd_loc = LOC_SERIAL;
      CMD_MFR_NAME: cmd_loc = LOC_MFR_LEN;
      CMD_DEV_NAME: cmd_loc = LOC_DEV_LEN;
      CMD_CHEM:     cmd_loc = LOC_CHEM_LEN;
      default:      cmd_loc = LOC_MDATA_LEN;
    endcase
  endfunction : cmd_loc

  function automatic logic [7:0] str_cap(input gcc_cmd_t c);
    case (c)
      CMD_MFR_NAME: str_cap = MFR_CAP;
      CMD_DEV_NAME: str_cap = DEV_CAP;
      CMD_CHEM:     str_cap = CHEM_CAP;
      default:      str_cap = 8'hff;
    endcase
  endfunction : str_cap

  function automatic logic is_word(input gcc_cmd_t c);
    is_word = (c == CMD_SPEC) || (c == CMD_DATE) || (c == CMD_SERIAL);
  endfunction : is_word

  logic               access;
  logic               busy;
  logic               in_mem;
  logic               known;
  logic               char_valid;
  logic [6:0]         char_loc;
  logic [6:0]         step_loc;
  logic [7:0]         len_clamped;
  logic [20:0]        meas_mag;
  logic [19:0]        cal_mag;
  logic               cal_sign;
  logic signed [20:0] ofs_value;
  logic signed [25:0] cur_sum;
  logic signed [48:0] chg_prod;
  logic signed [48:0] chg_scaled;
  logic signed [25:0] cur_scaled;

  assign access     = PSEL && PENABLE;
  assign busy       = (st_reg.seq != SEQ_IDLE);
  assign in_mem     = (PADDR[11:9] == MEM_WINDOW);
  assign known      = in_mem || (PADDR == REG_CTRL) || (PADDR == REG_STATUS)
                    || (PADDR == REG_CURRENT) || (PADDR == REG_CHARGE)
                    || (PADDR == REG_TEMP) || (PADDR == REG_CMD)
                    || (PADDR == REG_RESP) || (PADDR == REG_CHAR)
                    || (PADDR == REG_CANCEL);
  // characters follow the length byte in ascending order
  assign char_valid = (st_reg.str_idx < st_reg.str_len);
  assign char_loc   = cmd_loc(st_reg.cmd) + 7'h01 + st_reg.str_idx[6:0];
  assign step_loc   = cmd_loc(st_reg.cmd) + {6'h00, st_reg.step[0]};
  assign len_clamped = (mem_q > str_cap(st_reg.cmd)) ? str_cap(st_reg.cmd) : mem_q;

  // sign-magnitude conversion of the measured offset for storage
  assign cal_sign = MEAS.vfc_meas[20];
  assign meas_mag = cal_sign ? 21'(-MEAS.vfc_meas) : MEAS.vfc_meas;
  assign cal_mag  = meas_mag[20] ? VFC_MAG_MAX : meas_mag[19:0];

  // stored offset back to two's complement, zero sign bit is positive
  assign ofs_value = st_reg.vfc_ofs[VFC_SIGN_BIT]
                   ? -$signed({1'b0, st_reg.vfc_ofs[19:0]})
                   : $signed({1'b0, st_reg.vfc_ofs[19:0]});

  // arithmetic shift floors negative results rather than truncating to zero
  assign cur_sum    = 26'(MEAS.adc_raw)
                    + 26'($signed(st_reg.adc_ofs) * $signed({1'b0, st_reg.adc_gain}));
  assign cur_scaled = cur_sum >>> CUR_SHIFT;
  assign chg_prod   = 49'(MEAS.charge_raw) * $signed({1'b0, st_reg.vfc_gain});
  assign chg_scaled = chg_prod >>> CUR_SHIFT;

  always_comb begin
    st_next   = st_reg;
    mem_we    = 1'b0;
    mem_wdata = 8'h00;
    mem_addr  = AW'(PADDR[8:2]);
    PREADY    = 1'b0;
    PSLVERR   = 1'b0;

    st_next.res.current_ma  = cur_scaled[15:0];
    st_next.res.charge      = chg_scaled[31:0];
    st_next.res.temperature = MEAS.temp_raw + 16'($signed(st_reg.temp_ofs));
    st_next.res.vfc_cancel  = -ofs_value;

    case (st_reg.seq)
      SEQ_IDLE: begin
        if (PADDR == REG_CHAR) begin
          mem_addr = AW'(char_loc);
        end
        if (access && !st_reg.apb_wait) begin
          st_next.apb_wait = 1'b1;
          st_next.rd_mem   = in_mem;
          case (PADDR)
            REG_STATUS:  st_next.prdata = {28'h0000000, st_reg.cal_done,
                                           st_reg.loaded && (st_reg.chk1 == CHECK1_VALUE)
                                           && (st_reg.chk2 == CHECK2_VALUE),
                                           st_reg.loaded, 1'b0};
            REG_CURRENT: st_next.prdata = 32'(st_reg.res.current_ma);
            REG_CHARGE:  st_next.prdata = st_reg.res.charge;
            REG_TEMP:    st_next.prdata = 32'(st_reg.res.temperature);
            REG_CMD:     st_next.prdata = {29'h00000000, st_reg.cmd};
            REG_RESP:    st_next.prdata = {16'h0000, st_reg.resp};
            REG_CANCEL:  st_next.prdata = 32'(st_reg.res.vfc_cancel);
            default:     st_next.prdata = 32'h00000000;
          endcase
        end else if (access) begin
          PREADY           = 1'b1;
          PSLVERR          = !known;
          st_next.apb_wait = 1'b0;
          st_next.rd_mem   = 1'b0;
          if (PWRITE && in_mem) begin
            mem_we    = 1'b1;
            mem_wdata = PWDATA[7:0];
          end else if (PWRITE && (PADDR == REG_CTRL)) begin
            if (PWDATA[CTRL_LOAD]) begin
              st_next.seq    = SEQ_LOAD;
              st_next.step   = 4'h0;
              st_next.loaded = 1'b0;
            end else if (PWDATA[CTRL_CAL]) begin
              // host-issued calibration request captures the measured offset
              st_next.seq      = SEQ_CAL;
              st_next.step     = 4'h0;
              st_next.cal_done = 1'b0;
              st_next.vfc_ofs  = {st_reg.vfc_ofs[23:21], cal_sign, cal_mag};
            end
          end else if (PWRITE && (PADDR == REG_CMD)) begin
            st_next.cmd     = gcc_cmd_t'(PWDATA[2:0]);
            st_next.seq     = SEQ_CMD;
            st_next.step    = 4'h0;
            st_next.resp    = 16'h0000;
            st_next.str_len = 8'h00;
            st_next.str_idx = 8'h00;
          end else if (!PWRITE && (PADDR == REG_CHAR) && char_valid) begin
            st_next.str_idx = st_reg.str_idx + 8'h01;
          end
        end
      end

      SEQ_LOAD: begin
        mem_addr = AW'(load_loc(st_reg.step));
        if (st_reg.step != 4'h0) begin
          // lower location is the least significant byte
          case (st_reg.step - 4'h1)
            4'h0:    st_next.chk1[7:0]      = mem_q;
            4'h1:    st_next.chk1[15:8]     = mem_q;
            4'h2:    st_next.chk2[7:0]      = mem_q;
            4'h3:    st_next.chk2[15:8]     = mem_q;
            4'h4:    st_next.vfc_ofs[7:0]   = mem_q;
            4'h5:    st_next.vfc_ofs[15:8]  = mem_q;
            4'h6:    st_next.vfc_ofs[23:16] = mem_q;
            4'h7:    st_next.temp_ofs       = mem_q;
            4'h8:    st_next.adc_ofs        = mem_q;
            4'h9:    st_next.adc_gain[7:0]  = mem_q;
            4'ha:    st_next.adc_gain[15:8] = mem_q;
            4'hb:    st_next.vfc_gain[7:0]  = mem_q;
            default: st_next.vfc_gain[15:8] = mem_q;
          endcase
        end
        if (st_reg.step == LOAD_STEPS) begin
          st_next.seq    = SEQ_IDLE;
          st_next.loaded = 1'b1;
        end else begin
          st_next.step = st_reg.step + 4'h1;
        end
      end

      SEQ_CAL: begin
        // upper three bits of the last byte are left as loaded
        mem_we    = 1'b1;
        mem_addr  = AW'(LOC_VFC_OFS + {3'h0, st_reg.step});
        mem_wdata = (st_reg.step == 4'h0) ? st_reg.vfc_ofs[7:0]
                  : (st_reg.step == 4'h1) ? st_reg.vfc_ofs[15:8]
                  : st_reg.vfc_ofs[23:16];
        if (st_reg.step == CAL_STEPS - 4'h1) begin
          st_next.seq      = SEQ_IDLE;
          st_next.cal_done = 1'b1;
        end else begin
          st_next.step = st_reg.step + 4'h1;
        end
      end

      SEQ_CMD: begin
        mem_addr = AW'(step_loc);
        if (st_reg.step == 4'h1) begin
          if (is_word(st_reg.cmd)) begin
            st_next.resp[7:0] = mem_q;
          end else if (st_reg.cmd == CMD_MDATA) begin
            st_next.resp = {8'h00, mem_q};
            st_next.seq  = SEQ_IDLE;
          end else begin
            st_next.resp    = {8'h00, len_clamped};
            st_next.str_len = len_clamped;
            st_next.seq     = SEQ_IDLE;
          end
        end
        if (st_reg.step == 4'h2) begin
          st_next.resp[15:8] = mem_q;
          st_next.seq        = SEQ_IDLE;
        end else begin
          st_next.step = st_reg.step + 4'h1;
        end
      end

      default: begin
        st_next.seq = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_reg          <= '0;
      st_reg.seq      <= SEQ_IDLE;
      st_reg.cmd      <= CMD_SPEC;
      st_reg.adc_gain <= GAIN_RST;
      st_reg.vfc_gain <= GAIN_RST;
      st_reg.adc_ofs  <= BYTE_RST;
      st_reg.temp_ofs <= BYTE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // memory and character reads come straight from the memory output flop
  assign PRDATA = !st_reg.rd_mem && (PADDR != REG_CHAR) ? st_reg.prdata
                : (PADDR == REG_CHAR) ? {23'h000000, char_valid,
                                         char_valid ? mem_q : 8'h00}
                : {24'h000000, mem_q};
  assign RESULT = st_reg.res;

endmodule : gcc_top

`default_nettype wire

// ### dv/gcc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none

module gcc_chk_sva #(
  parameter int AW = 7
) (
  // clock and reset
  input wire logic                 CLOCK,
  input wire logic                 RST,
  // apb
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [11:0]          PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic [31:0]          PRDATA,
  input wire logic                 PREADY,
  input wire logic                 PSLVERR,
  // measurement
  input wire gcc_pkg::gcc_meas_t   MEAS,
  input wire gcc_pkg::gcc_result_t RESULT
);
  import gcc_pkg::*;

  logic               cal_fire;
  logic signed [20:0] cal_exp_reg;
  logic signed [15:0] raw_reg;
  logic        [4:0]  quiet_reg;
  logic signed [15:0] tdiff;

  assign cal_fire = PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_CTRL
                    && PWDATA[1:0] == 2'b10;
  assign tdiff = RESULT.temperature - raw_reg;

  // quiet counts cycles since any control access, so a reload cannot move the offset
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cal_exp_reg <= '0;
      raw_reg <= '0;
      quiet_reg <= '0;
    end else begin
      if (cal_fire) begin
        // the most negative reading clamps to full magnitude
        cal_exp_reg <= (MEAS.vfc_meas == 21'sh100000) ? 21'sh0fffff : -MEAS.vfc_meas;
      end
      raw_reg <= MEAS.temp_raw;
      quiet_reg <= (PSEL && PADDR == REG_CTRL) ? 5'h00 :
                   (quiet_reg == 5'h1f) ? quiet_reg : quiet_reg + 5'h01;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  a_ready_second_access: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && PENABLE))
    else $error("ready outside second access cycle");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held two cycles");
  a_unmapped_err: assert property (PREADY && PADDR > REG_CANCEL && PADDR < 12'h200 |-> PSLVERR)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (PREADY && PADDR[1:0] == 2'b00
      && (PADDR <= REG_CANCEL || PADDR[11:9] == MEM_WINDOW) |-> !PSLVERR)
    else $error("mapped access refused");
  a_cal_cancel: assert property (cal_fire |=> ##[0:6] RESULT.vfc_cancel == cal_exp_reg)
    else $error("cancel value not opposite to measured offset");
  a_temp_offset: assert property (quiet_reg >= 5'h18 |-> $stable(tdiff))
    else $error("temperature correction drifts");
  a_charge_zero: assert property ($past(MEAS.charge_raw) == 32'sh0 |-> RESULT.charge == 32'sh0)
    else $error("charge nonzero for zero input");
  a_char_empty: assert property (PREADY && !PWRITE && PADDR == REG_CHAR && !PRDATA[8]
      |-> PRDATA[7:0] == 8'h00)
    else $error("character data past string end");
endmodule : gcc_chk_sva

bind gcc_top gcc_chk_sva #(.AW(AW)) u_chk (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS(MEAS), .RESULT(RESULT));

`default_nettype wire

// ### dv/gcc_img_model.sv
`timescale 1ns/1ps
`default_nettype none

module gcc_img_model (
  // configuration image bytes
  output logic [7:0] img [128]
);
  import gcc_pkg::*;

  always_comb begin
    // spare bytes carry a changing pattern so stale reads are caught
    for (int i = 0; i < 128; i++) begin
      img[i] = 8'h5a ^ 8'(i);
    end
    {img[LOC_CHECK1_HI], img[LOC_CHECK1_LO]} = CHECK1_VALUE;
    {img[LOC_CHECK2_HI], img[LOC_CHECK2_LO]} = CHECK2_VALUE;
    // longer than the field, so the answer must clamp
    img[LOC_MFR_LEN] = 8'h0c;
    img[LOC_DEV_LEN] = 8'h03;
    img[LOC_CHEM_LEN] = 8'h04;
    for (int k = 0; k < 10; k++) begin
      img[7'h21 + 7'(k)] = 8'h41 + 8'(k);
    end
    for (int k = 0; k < 7; k++) begin
      img[7'h31 + 7'(k)] = 8'h61 + 8'(k);
    end
    for (int k = 0; k < 4; k++) begin
      img[7'h41 + 7'(k)] = 8'h30 + 8'(k);
    end
    img[LOC_MDATA_LEN] = 8'h07;
    img[LOC_TEMP_OFS] = 8'he7;
    // negative, so a byte taken as unsigned gives a wrong current
    img[LOC_ADC_OFS] = 8'hfb;
    {img[7'h69], img[LOC_ADC_GAIN]} = 16'h1000;
    {img[7'h6b], img[LOC_VFC_GAIN]} = 16'h2000;
  end
endmodule : gcc_img_model

`default_nettype wire

// ### dv/gcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gcc_top_tb;
  import gcc_pkg::*;

  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } gcc_note_t;

  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  gcc_meas_t   meas;
  gcc_result_t result;
  logic [7:0]  img [128];
  gcc_note_t   notes[$];
  gcc_note_t   cur;
  int          mismatches, check_count;

  gcc_top #(.AW(7)) uut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEAS(meas), .RESULT(result));
  gcc_img_model u_img (.img(img));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // request stands until the rising edge that samples ready; one idle cycle follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    n = 0;
    notes.push_back('{d, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) begin
        mismatches++;
        test_done();
      end
    end while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  always @(posedge clock) begin
    if (psel && penable && pready) begin
      cur = notes.pop_front();
      chk(prdata & cur.m, cur.d & cur.m);
      chk({31'h0, pslverr}, {31'h0, cur.e});
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    test_done();
  end

  initial begin
    int                 c, vg, ofs, gain;
    logic [7:0]         len, cap;
    logic [6:0]         l;
    logic signed [15:0] a, t;
    logic signed [31:0] ch;
    longint             q;
    logic signed [20:0] v;
    logic               sgn;
    logic [19:0]        mag;
    logic [23:0]        fld;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    meas = '0;
    mismatches = 0;
    check_count = 0;
    seed = 32'h000111bc;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 128; i++) apb(1'b1, 12'h200 + 12'(4 * i), {24'h0, img[i]}, 32'h0, 1'b0);
    apb(1'b0, 12'h204, {24'h0, img[1]}, 32'hffffffff, 1'b0);
    apb(1'b1, REG_CTRL, 32'h1, 32'h0, 1'b0);
    apb(1'b0, REG_STATUS, 32'h6, 32'hf, 1'b0);
    for (c = 0; c < 7; c++) begin
      apb(1'b1, REG_CMD, 32'(c), 32'h0, 1'b0);
      if (c < 3) begin
        l = LOC_SPEC + 7'(2 * c);
        apb(1'b0, REG_RESP, {16'h0, img[l + 7'h01], img[l]}, 32'hffff, 1'b0);
      end else if (c == 6) begin
        apb(1'b0, REG_RESP, 32'h7, 32'hff, 1'b0);
      end else begin
        l = (c == 3) ? LOC_MFR_LEN : (c == 4) ? LOC_DEV_LEN : LOC_CHEM_LEN;
        cap = (c == 3) ? MFR_CAP : (c == 4) ? DEV_CAP : CHEM_CAP;
        len = (img[l] < cap) ? img[l] : cap;
        apb(1'b0, REG_RESP, {24'h0, len}, 32'hff, 1'b0);
        for (int k = 0; k <= int'(len); k++) apb(1'b0, REG_CHAR, (k < int'(len)) ?
          {23'h0, 1'b1, img[l + 7'h01 + 7'(k)]} : 32'h0, 32'h1ff, 1'b0);
      end
    end
    ofs = int'($signed(img[LOC_ADC_OFS]));
    gain = int'({img[7'h69], img[LOC_ADC_GAIN]});
    vg = int'({img[7'h6b], img[LOC_VFC_GAIN]});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      {t, a} = seed;
      seed = lfsr(seed);
      ch = (i == 0) ? 32'sh0 : seed;
      meas.adc_raw <= a;
      meas.temp_raw <= t;
      meas.charge_raw <= ch;
      q = (longint'(a) + ofs * gain) >>> 14;
      apb(1'b0, REG_CURRENT, 32'(q), 32'hffff, 1'b0);
      q = (longint'(ch) * vg) >>> 14;
      apb(1'b0, REG_CHARGE, 32'(q), 32'hffffffff, 1'b0);
      q = longint'(t) + longint'($signed(img[LOC_TEMP_OFS]));
      apb(1'b0, REG_TEMP, 32'(q), 32'hffff, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      seed = lfsr(seed);
      v = (j == 0) ? 21'sh100000 : $signed(seed[20:0]);
      meas.vfc_meas <= v;
      apb(1'b1, REG_CTRL, 32'h2, 32'h0, 1'b0);
      sgn = v[20];
      mag = (v == 21'sh100000) ? 20'hfffff : sgn ? 20'(-v) : v[19:0];
      fld = {img[LOC_VFC_OFS + 7'h02][7:5], sgn, mag};
      apb(1'b0, REG_CANCEL, sgn ? 32'(mag) : -32'(mag), 32'h1fffff, 1'b0);
      for (int b = 0; b < 3; b++) apb(1'b0, 12'h200 + 12'(4 * (int'(LOC_VFC_OFS) + b)),
        {24'h0, fld[8 * b +: 8]}, 32'hff, 1'b0);
    end
    apb(1'b0, REG_STATUS, 32'he, 32'hf, 1'b0);
    apb(1'b0, 12'h0fc, 32'h0, 32'h0, 1'b1);
    test_done();
  end
endmodule : gcc_top_tb

`default_nettype wire
